// >>> hdl/cpm_top.sv
// clock and power mode control: registers, flags, wake switch, trimming
//
// Behaviour
// [RQ1] mode done on leaving super economy
// [RQ2] stable flag when oscillator wait ends
// [RQ3] stop flag on clock stop or enable fall
// [RQ4] trim done flag when trimming finishes
// [RQ5] flags clear by writing one
// [RQ6] interrupt only for enabled set flag
// [RQ7] mode done only while slow crystal runs
// [RQ8] auto mode sleep sets mode done later
// [RQ9] regulator mode codes auto normal eco super
// [RQ10] reserved mode code stores automatic
// [RQ11] pump clock divides slow crystal 32..256
// [RQ12] wake switch copies wake source, divider
// [RQ13] source and divider code table
// [RQ14] selected stopped source starts automatically
// [RQ15] sleep stop bits, reset to one
// [RQ16] enable bits start sources, internal on
// [RQ17] trim run bit starts, self clears
// [RQ18] software waits slow crystal stable first
// [RQ19] no internal clock use while trimming
// [RQ20] no wake switch with sleep bit zero
// [RQ21] stopped wake source needs enable first
// [RQ22] protected bits need unlock key
// [RQ23] reserved bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "cpm_defs.svh"
module cpm_top #(
  parameter int unsigned MODE_WAIT = `CPM_WAIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [15:0] rdata_q,
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  input  wire logic        high_speed_busy,
  input  wire logic        slow_crystal_running,
  output var  logic [3:0]  source_run_q,
  output var  logic [2:0]  regulator_mode_q,
  output var  logic [1:0]  sys_clock_source_q,
  output var  logic [1:0]  sys_clock_divider_q,
  output var  logic [8:0]  pump_div_ratio_q,
  output var  logic        trim_active_q,
  output var  logic        irq_regulator_q,
  output var  logic        irq_clock_q
);
  logic       unlocked_q;
  logic [2:0] mode_q;
  logic [1:0] pump_q;
  logic       mode_flag_q;
  logic       mode_ien_q;
  logic       wake_en_q;
  logic [1:0] wake_src_q;
  logic [1:0] wake_div_q;
  logic [1:0] src_q;
  logic [1:0] div_q;
  logic [3:0] sleep_stop_q;
  logic [3:0] osc_en_q;
  logic       sd_restart_q;
  logic       sd_enable_q;
  logic [5:0] clk_flag_q;
  logic [5:0] clk_ien_q;
  logic       sleeping_q;
  logic       sc_run;
  logic       prev_super_q;
  logic       eco_auto_q;
  logic       sleep_armed_q;
  logic [3:0] run_d;
  logic [3:0] run_q;
  logic [2:0] stab_done;
  logic       trim_busy;
  logic       trim_done;
  logic       mwait_busy;
  logic       mwait_done;
  logic       w_reg_mode;
  logic       w_osc;
  logic       w_sd;
  logic       w_trim;
  logic       trim_start;
  logic       trim_stop;
  logic       slow_crystal_stop_evt;
  logic       mode_evt;
  logic [5:0] clk_set;
  logic [5:0] clk_clr;
  // slow crystal status comes from the analog side, so it is filtered
  cpm_sync u_sc_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (slow_crystal_running),
    .level_q  (sc_run)
  );
  assign w_reg_mode = wr && unlocked_q && addr == `CPM_OFF_REG_MODE;
  assign w_osc      = wr && addr == `CPM_OFF_OSC;
  assign w_sd       = wr && unlocked_q && addr == `CPM_OFF_SLOW_CTRL;
  assign w_trim     = wr && unlocked_q && addr == `CPM_OFF_TRIM;
  assign trim_start = w_trim && wdata[`CPM_TRIM_RUN_BIT] && !trim_busy;
  assign trim_stop  = w_trim && !wdata[`CPM_TRIM_RUN_BIT];
  // protection key register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      unlocked_q <= 1'b0;
    end else if (wr && addr == `CPM_OFF_PROTECT) begin
      unlocked_q <= (wdata == `CPM_UNLOCK_KEY); // [RQ22]
    end
  end
  // regulator mode and pump clock
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_q <= 3'h0;
      pump_q <= 2'h0;
    end else begin
      if (w_reg_mode) begin
        case (wdata[2:0])
          cpm_pkg::CPM_MODE_NORMAL,
          cpm_pkg::CPM_MODE_ECO,
          cpm_pkg::CPM_MODE_SUPER: mode_q <= wdata[2:0]; // [RQ9]
          default: mode_q <= cpm_pkg::CPM_MODE_AUTO; // [RQ10]
        endcase
      end
      if (wr && unlocked_q && addr == `CPM_OFF_PUMP) begin
        pump_q <= wdata[1:0];
      end
    end
  end
  // charge pump ratio: 32 shifted by the field
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pump_div_ratio_q <= 9'h020;
    end else begin
      pump_div_ratio_q <= 9'h020 << pump_q; // [RQ11]
    end
  end
  // system clock selection with wake switch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_en_q  <= 1'b0;
      wake_src_q <= 2'h0;
      wake_div_q <= 2'h0;
      src_q      <= 2'h0;
      div_q      <= 2'h0;
    end else if (sleeping_q && wake_req && wake_en_q) begin
      src_q <= wake_src_q; // [RQ12]
      div_q <= wake_div_q;
    end else if (wr && unlocked_q && addr == `CPM_OFF_SCLK) begin
      wake_en_q  <= wdata[`CPM_SCLK_WAKE_EN];
      wake_div_q <= wdata[13:12];
      wake_src_q <= wdata[9:8];
      src_q      <= wdata[1:0]; // [RQ13]
      div_q      <= wdata[5:4];
    end
  end
  // reserved divider codes are stored but only valid ones reach the output
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sys_clock_source_q  <= 2'h0;
      sys_clock_divider_q <= 2'h0;
    end else begin
      sys_clock_source_q <= src_q;
      case (src_q)
        2'h1:    sys_clock_divider_q <= {1'b0, div_q[0]}; // [RQ13]
        2'h3:    sys_clock_divider_q <= 2'h0;
        default: sys_clock_divider_q <= div_q;
      endcase
    end
  end
  // oscillator enables and sleep stop bits, with automatic start
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      osc_en_q     <= 4'(`CPM_OSC_RESET);
      sleep_stop_q <= 4'hf; // [RQ15]
    end else begin
      if (w_osc) begin
        osc_en_q     <= wdata[3:0]; // [RQ16]
        sleep_stop_q <= wdata[11:8];
      end else if (!osc_en_q[src_q]) begin
        osc_en_q[src_q] <= 1'b1; // [RQ14]
      end
    end
  end
  // slow crystal stop detector controls
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sd_restart_q <= 1'b0;
      sd_enable_q  <= 1'b0;
    end else if (w_sd) begin
      sd_restart_q <= wdata[`CPM_SD_RESTART_BIT];
      sd_enable_q  <= wdata[`CPM_SD_ENABLE_BIT];
    end
  end
  // sleep state tracking
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sleeping_q <= 1'b0;
    end else if (wake_req) begin
      sleeping_q <= 1'b0;
    end else if (sleep_req) begin
      sleeping_q <= 1'b1;
    end
  end
  // a source runs when enabled unless sleep stops it
  always_comb begin
    run_d = osc_en_q & ~(sleep_stop_q & {4{sleeping_q}}); // [RQ15]
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_q        <= 4'h1;
      source_run_q <= 4'h1;
    end else begin
      run_q        <= run_d;
      source_run_q <= run_d; // [RQ16]
    end
  end
  // stabilisation waits restart on every rising run level of sources 0 to 2; source 3 has no wait
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_stab
      cpm_counter #(.LEN(`CPM_STAB_CYCLES)) u_wait (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (run_d[gi] && !run_q[gi]),
        .abort   (!run_d[gi]),
        .busy_q  (),
        .done_q  (stab_done[gi]) // [RQ2]
      );
    end
  endgenerate
  // trimming needs the slow crystal; without it a start is dropped, bit reads 0
  cpm_counter #(.LEN(`CPM_TRIM_CYCLES)) u_trim (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (trim_start && sc_run), // [RQ17]
    .abort   (trim_stop),
    .busy_q  (trim_busy),
    .done_q  (trim_done) // [RQ4]
  );
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trim_active_q <= 1'b0;
    end else begin
      trim_active_q <= trim_busy; // [RQ17]
    end
  end
  // automatic mode: one millisecond after slow-only sleep
  cpm_counter #(.LEN(MODE_WAIT)) u_mwait (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (sleep_armed_q),
    .abort   (!sleeping_q),
    .busy_q  (mwait_busy),
    .done_q  (mwait_done)
  );
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_super_q  <= 1'b0;
      eco_auto_q    <= 1'b0;
      sleep_armed_q <= 1'b0;
    end else begin
      prev_super_q  <= (mode_q == cpm_pkg::CPM_MODE_SUPER);
      eco_auto_q    <= (mode_q == cpm_pkg::CPM_MODE_AUTO) && high_speed_busy;
      sleep_armed_q <= sleep_req && !sleeping_q && run_d[1]
                       && run_d[3:2] == 2'h0 && !run_d[0]
                       && mode_q == cpm_pkg::CPM_MODE_AUTO; // [RQ8]
    end
  end
  assign mode_evt = sc_run && ( // [RQ7]
    (prev_super_q && mode_q != cpm_pkg::CPM_MODE_SUPER) || // [RQ1]
    (eco_auto_q && !high_speed_busy
     && mode_q == cpm_pkg::CPM_MODE_AUTO) ||
    (mwait_done && !mwait_busy)); // [RQ8]
  // regulator flag and enable; set wins over clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_flag_q <= 1'b0;
      mode_ien_q  <= 1'b0;
    end else begin
      if (mode_evt) begin
        mode_flag_q <= 1'b1;
      end else if (wr && addr == `CPM_OFF_REG_FLAGS && wdata[0]) begin
        mode_flag_q <= 1'b0; // [RQ5]
      end
      if (wr && addr == `CPM_OFF_REG_IEN) begin
        mode_ien_q <= wdata[0];
      end
    end
  end
  assign slow_crystal_stop_evt = (run_q[1] && !sc_run && sd_enable_q)
    || (w_osc && osc_en_q[1] && !wdata[1])
    || (w_sd && sd_enable_q && !wdata[`CPM_SD_ENABLE_BIT]); // [RQ3]
  always_comb begin
    clk_set = {slow_crystal_stop_evt, trim_done, 1'b0, stab_done[2:0]};
    clk_clr = 6'h00;
    if (wr && addr == `CPM_OFF_CLK_FLAGS) begin
      clk_clr = wdata[5:0] & 6'h37; // [RQ5]
    end
  end
  // clock flags and enables
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clk_flag_q <= 6'h00;
      clk_ien_q  <= 6'h00;
    end else begin
      clk_flag_q <= clk_set | (clk_flag_q & ~clk_clr); // [RQ5]
      if (wr && addr == `CPM_OFF_CLK_IEN) begin
        clk_ien_q <= wdata[5:0] & 6'h37;
      end
    end
  end
  // interrupt requests
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_regulator_q  <= 1'b0;
      irq_clock_q      <= 1'b0;
      regulator_mode_q <= 3'h0;
    end else begin
      irq_regulator_q  <= mode_flag_q && mode_ien_q; // [RQ6]
      irq_clock_q      <= |(clk_flag_q & clk_ien_q); // [RQ6]
      regulator_mode_q <= mode_q;
    end
  end
  // read port, reserved bits zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      if (addr == `CPM_OFF_REG_MODE) begin
        rdata_q <= {13'h0000, mode_q}; // [RQ23]
      end else if (addr == `CPM_OFF_PUMP) begin
        rdata_q <= {14'h0000, pump_q};
      end else if (addr == `CPM_OFF_REG_FLAGS) begin
        rdata_q <= {15'h0000, mode_flag_q};
      end else if (addr == `CPM_OFF_REG_IEN) begin
        rdata_q <= {15'h0000, mode_ien_q};
      end else if (addr == `CPM_OFF_SCLK) begin
        rdata_q <= {wake_en_q, 1'b0, wake_div_q, 2'h0, wake_src_q,
                    2'h0, div_q, 2'h0, src_q};
      end else if (addr == `CPM_OFF_OSC) begin
        rdata_q <= {4'h0, sleep_stop_q, 4'h0, osc_en_q};
      end else if (addr == `CPM_OFF_TRIM) begin
        rdata_q <= {11'h000, trim_busy, 4'h0}; // [RQ17]
      end else if (addr == `CPM_OFF_SLOW_CTRL) begin
        rdata_q <= {1'b0, sd_restart_q, sd_enable_q, 13'h0000};
      end else if (addr == `CPM_OFF_CLK_FLAGS) begin
        rdata_q <= {10'h000, clk_flag_q};
      end else if (addr == `CPM_OFF_CLK_IEN) begin
        rdata_q <= {10'h000, clk_ien_q};
      end else begin
        rdata_q <= 16'h0000;
      end
    end else begin
      rdata_q <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/cpm_defs.svh
// offsets, field positions, reset values and timing counts of the clock and power mode block
`ifndef CPM_DEFS_SVH
`define CPM_DEFS_SVH
`define CPM_OFF_REG_MODE   4'h0
`define CPM_OFF_PUMP       4'h1
`define CPM_OFF_REG_FLAGS  4'h2
`define CPM_OFF_REG_IEN    4'h3
`define CPM_OFF_SCLK       4'h4
`define CPM_OFF_OSC        4'h5
`define CPM_OFF_TRIM       4'h6
`define CPM_OFF_SLOW_CTRL  4'h7
`define CPM_OFF_CLK_FLAGS  4'h8
`define CPM_OFF_CLK_IEN    4'h9
`define CPM_OFF_PROTECT    4'ha
`define CPM_UNLOCK_KEY     16'h0096
`define CPM_OSC_RESET      16'h0f01
`define CPM_SCLK_WAKE_EN   15
`define CPM_TRIM_RUN_BIT   4
`define CPM_SD_RESTART_BIT 14
`define CPM_SD_ENABLE_BIT  13
`define CPM_FLAG_STOP      5
`define CPM_FLAG_TRIM      4
`define CPM_WAIT_US        1000
`define CPM_CLK_MHZ        10
`define CPM_WAIT_CYCLES    (`CPM_WAIT_US * `CPM_CLK_MHZ)
`define CPM_STAB_CYCLES    64
`define CPM_TRIM_CYCLES    256
`endif

// >>> hdl/cpm_pkg.sv
// types of the clock and power mode block
package cpm_pkg;
  typedef enum logic [2:0] {
    CPM_MODE_AUTO   = 3'h0,
    CPM_MODE_NORMAL = 3'h2,
    CPM_MODE_ECO    = 3'h3,
    CPM_MODE_SUPER  = 3'h5
  } cpm_mode_t;
  typedef enum logic [2:0] {
    CPM_TR_IDLE = 3'h1,
    CPM_TR_RUN  = 3'h2,
    CPM_TR_DONE = 3'h4
  } cpm_trim_t;
endpackage

// >>> hdl/cpm_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cpm_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output var  logic level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/cpm_counter.sv
// down counter that pulses done when a started wait runs out
`timescale 1ns/1ps
`default_nettype none
module cpm_counter #(
  parameter int unsigned LEN = 64
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic abort,
  output var  logic busy_q,
  output var  logic done_q
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q  <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (abort) begin
        busy_q <= 1'b0;
      end else if (start) begin
        cnt_q  <= 16'(LEN - 1);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == 16'h0000) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/cpm_checker.sv
// port checker for the clock and power mode block
`timescale 1ns/1ps
`default_nettype none
module cpm_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata_q,
  input wire logic        sleep_req,
  input wire logic        wake_req,
  input wire logic [3:0]  source_run_q,
  input wire logic [2:0]  regulator_mode_q,
  input wire logic [1:0]  sys_clock_source_q,
  input wire logic [1:0]  sys_clock_divider_q,
  input wire logic [8:0]  pump_div_ratio_q,
  input wire logic        trim_active_q,
  input wire logic        irq_clock_q
);
  logic       key_ok_q;
  logic       asleep_q;
  logic       sclk_wr_q;
  logic       wake_q;
  logic [9:0] trim_cnt_q;
  // shadow of the protection state, so refused writes can be judged
  always_ff @(posedge clk) begin
    if (!reset_n)
      key_ok_q <= 1'b0;
    else if (wr && addr == 4'ha)
      key_ok_q <= (wdata == 16'h0096);
  end
  always_ff @(posedge clk) begin
    if (!reset_n)
      asleep_q <= 1'b0;
    else if (sleep_req || wake_req)
      asleep_q <= sleep_req;
  end
  always_ff @(posedge clk) begin
    sclk_wr_q <= wr && addr == 4'h4;
    wake_q <= wake_req;
  end
  // counter instead of a long repetition keeps the tools fast
  always_ff @(posedge clk) begin
    if (!reset_n || !trim_active_q)
      trim_cnt_q <= 10'h000;
    else
      trim_cnt_q <= trim_cnt_q + 10'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  reset_value_a:
    assert property (disable iff (1'b0) !reset_n |=> source_run_q == 4'h1
      && regulator_mode_q == 3'h0 && pump_div_ratio_q == 9'h020)
    else $error("reset values wrong");
  rd_idle_zero_a:
    assert property (!rd |=> rdata_q == 16'h0000)
    else $error("read data not zero outside answer");
  mode_legal_a:
    assert property (regulator_mode_q inside {3'h0, 3'h2, 3'h3, 3'h5})
    else $error("regulator mode holds reserved code");
  // the outputs sit two register stages behind the written field
  reserved_mode_a:
    assert property (wr && addr == 4'h0 && key_ok_q
      && wdata[2:0] inside {3'h1, 3'h4, 3'h6, 3'h7}
      |-> ##2 regulator_mode_q == 3'h0)
    else $error("reserved mode code not stored as automatic");
  locked_write_a:
    assert property (wr && addr == 4'h0 && !key_ok_q
      |-> ##2 $stable(regulator_mode_q))
    else $error("locked mode write took effect");
  pump_ratio_a:
    assert property (wr && addr == 4'h1 && key_ok_q
      |-> ##2 pump_div_ratio_q == (9'h020 << $past(wdata[1:0], 2)))
    else $error("pump ratio does not follow code");
  clk_change_a:
    assert property ($changed(sys_clock_source_q)
      |-> $past(sclk_wr_q) || $past(wake_q))
    else $error("clock source changed without cause");
  div_fold_a:
    assert property (sys_clock_source_q == 2'h3 |-> sys_clock_divider_q == 2'h0)
    else $error("external source with divider");
  auto_start_a:
    assert property (!asleep_q && !source_run_q[sys_clock_source_q]
      |-> ##[1:80] source_run_q[sys_clock_source_q])
    else $error("selected source not started");
  trim_bound_a:
    assert property (trim_cnt_q <= 10'h12c)
    else $error("trimming never finishes");
  irq_fall_a:
    assert property ($fell(irq_clock_q) |-> $past(wr) || $past(wr, 2))
    else $error("clock interrupt dropped without write");
  cover property (wr && addr == 4'h0 && key_ok_q);
  cover property ($rose(trim_active_q));
  cover property ($rose(irq_clock_q));
endmodule
bind cpm_top cpm_checker i_checker (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata_q(rdata_q), .sleep_req(sleep_req), .wake_req(wake_req),
  .source_run_q(source_run_q), .regulator_mode_q(regulator_mode_q),
  .sys_clock_source_q(sys_clock_source_q),
  .sys_clock_divider_q(sys_clock_divider_q),
  .pump_div_ratio_q(pump_div_ratio_q), .trim_active_q(trim_active_q),
  .irq_clock_q(irq_clock_q)
);
`default_nettype wire

// >>> bench/cpm_top_tb.sv
// self-checking bench for the clock and power mode block
`timescale 1ns/1ps
`default_nettype none
module cpm_top_tb;
  logic        clk, reset_n, wr, rd, sleep_req, wake_req, busy, slow_run;
  logic        trim, irq_r, irq_c;
  logic [3:0]  addr, run;
  logic [15:0] wdata, rdata, v;
  logic [2:0]  mode;
  logic [1:0]  src, div;
  logic [8:0]  pump;
  int          bad_count, compares;
  localparam logic [2:0] MODE_EXP [8] = '{3'h0, 3'h0, 3'h2, 3'h3,
                                          3'h0, 3'h5, 3'h0, 3'h0};
  cpm_top #(.MODE_WAIT(20)) i_dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata), .sleep_req(sleep_req), .wake_req(wake_req),
    .high_speed_busy(busy), .slow_crystal_running(slow_run),
    .source_run_q(run), .regulator_mode_q(mode), .sys_clock_source_q(src),
    .sys_clock_divider_q(div), .pump_div_ratio_q(pump),
    .trim_active_q(trim), .irq_regulator_q(irq_r), .irq_clock_q(irq_c)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic print_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // outputs sit two registers behind the written field
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(rdata & m, e);
  endtask
  // sel 0 regulator irq, 1 clock irq, 2 trimming over
  task automatic wait_on(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (sel == 0 && irq_r === 1'b1) return;
      if (sel == 1 && irq_c === 1'b1) return;
      if (sel == 2 && trim === 1'b0) return;
    end
    chk(16'(sel), 16'hffff);
    print_verdict();
  endtask
  task automatic pulse(input bit wake);
    @(posedge clk);
    if (wake)
      wake_req <= 1'b1;
    else
      sleep_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    chk(16'h0000, 16'h0001);
    print_verdict();
  end
  initial begin
    {reset_n, addr, wdata, wr, rd, sleep_req, wake_req, busy} = '0;
    slow_run = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i != 10) begin
        v = (i == 5) ? 16'h0f01 : 16'h0000;
        rd_chk(4'(i), 16'hffff, v);
      end
    end
    chk(16'(run), 16'h0001);
    $display("test reset values done");
    wr_reg(4'h0, 16'h0003);
    rd_chk(4'h0, 16'hffff, 16'h0000);
    wr_reg(4'ha, 16'h0096);
    for (int i = 0; i < 8; i++) begin
      wr_reg(4'h0, 16'hfff8 | 16'(i));
      chk(16'(mode), 16'(MODE_EXP[i]));
      rd_chk(4'h0, 16'hffff, 16'(MODE_EXP[i]));
    end
    rd_chk(4'h2, 16'hffff, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr_reg(4'h1, 16'hfffc | 16'(i));
      chk(16'(pump), 16'h0020 << i);
      rd_chk(4'h1, 16'hffff, 16'(i));
    end
    wr_reg(4'ha, 16'h0000);
    wr_reg(4'h0, 16'h0002);
    rd_chk(4'h0, 16'hffff, 16'h0000);
    $display("test modes and protection done");
    slow_run <= 1'b1;
    wr_reg(4'h5, 16'hffff);
    rd_chk(4'h5, 16'hffff, 16'h0f0f);
    rd_chk(4'h8, 16'hffff, 16'h0000);
    repeat (80) @(posedge clk);
    rd_chk(4'h8, 16'hffff, 16'h0006);
    wr_reg(4'h9, 16'h0002);
    wait_on(1, 5);
    wr_reg(4'h8, 16'h0000);
    rd_chk(4'h8, 16'h0007, 16'h0006);
    wr_reg(4'h8, 16'h0002);
    rd_chk(4'h8, 16'h0007, 16'h0004);
    chk(16'(irq_c), 16'h0000);
    wr_reg(4'h8, 16'h0037);
    wr_reg(4'h9, 16'h0020);
    wr_reg(4'h5, 16'h0f0d);
    rd_chk(4'h8, 16'h0020, 16'h0020);
    chk(16'(irq_c), 16'h0001);
    wr_reg(4'h5, 16'h0f0f);
    repeat (80) @(posedge clk);
    wr_reg(4'h8, 16'h0037);
    $display("test oscillator flags done");
    // move off the internal source and wait for a stable crystal first
    wr_reg(4'ha, 16'h0096);
    wr_reg(4'h4, 16'h0002);
    wr_reg(4'h9, 16'h0010);
    wr_reg(4'h6, 16'h0010);
    rd_chk(4'h6, 16'hffff, 16'h0010);
    wait_on(2, 400);
    rd_chk(4'h6, 16'hffff, 16'h0000);
    rd_chk(4'h8, 16'h0010, 16'h0010);
    chk(16'(irq_c), 16'h0001);
    $display("test trimming done");
    wr_reg(4'h4, 16'hb002);
    pulse(1'b0);
    pulse(1'b1);
    chk(16'({src, div}), 16'h0003);
    rd_chk(4'h4, 16'hffff, 16'hb030);
    wr_reg(4'h4, 16'h3112);
    pulse(1'b0);
    pulse(1'b1);
    rd_chk(4'h4, 16'hffff, 16'h3112);
    $display("test wake switch done");
    wr_reg(4'h5, 16'h0f07);
    wr_reg(4'h4, 16'h0033);
    chk(16'(div), 16'h0000);
    repeat (80) @(posedge clk);
    rd_chk(4'h5, 16'hffff, 16'h0f0f);
    chk(16'(run), 16'h000f);
    wr_reg(4'h4, 16'h0031);
    chk(16'(div), 16'h0001);
    wr_reg(4'h7, 16'hffff);
    rd_chk(4'h7, 16'hffff, 16'h6000);
    wr_reg(4'h8, 16'h0037);
    slow_run <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk(4'h8, 16'h0020, 16'h0020);
    slow_run <= 1'b1;
    repeat (8) @(posedge clk);
    wr_reg(4'h8, 16'h0037);
    rd_chk(4'h8, 16'h0020, 16'h0000);
    wr_reg(4'h7, 16'h0000);
    rd_chk(4'h8, 16'h0020, 16'h0020);
    $display("test auto start done");
    wr_reg(4'h3, 16'h0001);
    wr_reg(4'h2, 16'h0001);
    wr_reg(4'h0, 16'h0005);
    wr_reg(4'h0, 16'h0002);
    rd_chk(4'h2, 16'hffff, 16'h0001);
    wait_on(0, 5);
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h2, 16'h0001);
    rd_chk(4'h2, 16'hffff, 16'h0000);
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(4'h2, 16'hffff, 16'h0001);
    wr_reg(4'h5, 16'h0d02);
    wr_reg(4'h2, 16'h0001);
    wr_reg(4'h3, 16'h0000);
    pulse(1'b0);
    repeat (7) @(posedge clk);
    rd_chk(4'h2, 16'hffff, 16'h0000);
    repeat (20) @(posedge clk);
    rd_chk(4'h2, 16'hffff, 16'h0001);
    pulse(1'b1);
    $display("test mode done flag done");
    print_verdict();
  end
endmodule
`default_nettype wire
